// *** verilog/fpm_top.v ***
// Fieldbus process image mapper: cyclic assemblies, table polling,
// address choice and an AHB-Lite register slave.
// Assumes all inputs synchronous to hclk; bus idle while ce is low.
//
// Notes on behaviour
// - Each cyclic exchange carries exactly 17 or 32 bytes both ways.
// - Input instances 100 (32 bytes, tables) and 101 (17 bytes).
// - Output instances 150 and 151, configuration instance 4 of zero length.
// - Input n comes from bit n mod 8 of received byte n div 8.
// - Output n goes to bit n mod 8 of transmitted byte n div 8.
// - 128 inputs and 128 outputs, each selectable by configuration.
// - Status byte bits 0-4: output fault, input fault, fault, diagnostic, run.
// - Status byte bit 5 shows data exchange with the base unit.
// - Two request bytes, table and segment, return 15 segment bytes.
// - After reset or controller reset, starts by itself.
// - Address prefix 192.168.1, subnet mask 255.255.255.0.
// - Lowest octet from the eight-position switch, range 1 to 254.
// - DHCP enabled from new; switch zero then uses DHCP.
// - Under DHCP, no fieldbus traffic until an address is granted.
// - Switch 1 to 254 is the octet and disables DHCP.
// - Switch 255 forces DHCP regardless of configuration.
// - Switch zero with a stored fixed octet uses that octet.
// - Switch position 1 is the MSB, position 8 the LSB.
`timescale 1ns/1ps
`include "fpm_regs.vh"

module fpm_top #(
	parameter TBL_BITS = 2,
	parameter SEG_BITS = 3
) (
	input wire hclk,
	input wire hresetn,
	input wire ce,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	output reg irq,
	input wire rx_valid,
	input wire [7:0] rx_data,
	input wire rx_last,
	output reg tx_valid,
	output reg [7:0] tx_data,
	output reg tx_last,
	input wire tx_ready,
	input wire [127:0] ctl_outputs,
	input wire output_fault_indicator,
	input wire input_fault_indicator,
	input wire fault_indicator,
	input wire diagnostic_indicator,
	input wire run_indicator,
	input wire ctl_xchg_active,
	input wire ctl_reset,
	output reg [127:0] ctl_inputs,
	input wire [7:0] dip_sw,
	input wire dhcp_grant,
	input wire [7:0] dhcp_octet,
	output reg dhcp_req,
	output reg link_up
);
	localparam MAW = TBL_BITS + SEG_BITS + 4;
	localparam [1:0] S_IDLE = 2'd0;
	localparam [1:0] S_FETCH = 2'd1;
	localparam [1:0] S_LOAD = 2'd2;
	localparam [1:0] S_SEND = 2'd3;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	reg [31:0] ctrl_r;
	reg [`FPM_EV_W-1:0] stat_r;
	reg [`FPM_EV_W-1:0] mask_r;
	reg [MAW-1:0] taddr_r;
	reg [127:0] in_sel_r;
	reg [127:0] out_sel_r;
	reg wr_pend_r;
	reg [7:0] wr_ofs_r;
	reg [31:0] rd_mux;
	reg [`FPM_EV_W-1:0] ev;
	reg [127:0] in_shadow_r;
	reg [5:0] rx_cnt_r;
	reg [7:0] tbl_r;
	reg [7:0] seg_r;
	reg [1:0] state_r;
	reg [5:0] idx_r;
	reg [7:0] byte_mux;
	reg prev_ok_r;
	wire [7:0] ip_octet;
	wire use_dhcp;
	wire addr_ok;
	wire [7:0] mem_rd;
	wire short_asm = ctrl_r[`FPM_CTRL_SHORT];
	wire [5:0] asm_len = short_asm ? `FPM_LEN_SHORT : `FPM_LEN_LONG;
	wire [5:0] tbl_off = idx_r - `FPM_SEG_BYTE;
	wire seg_hit = (tbl_r[7:TBL_BITS] == 0) && (seg_r[7:SEG_BITS] == 0);
	wire [MAW-1:0] mem_ra = {tbl_r[TBL_BITS-1:0], seg_r[SEG_BITS-1:0], tbl_off[3:0]};
	wire acc = hsel & hready & htrans[1] & ce;
	wire [7:0] status_byte = {2'b00, ctl_xchg_active, run_indicator, diagnostic_indicator,
		fault_indicator, input_fault_indicator, output_fault_indicator};
	wire [127:0] out_img = ctl_outputs & out_sel_r;

	// Selector word for the 128-bit masks
	function [1:0] sel_word;
		input [7:0] ofs;
		begin
			sel_word = ofs[3:2];
		end
	endfunction

	// ----------------------------------------
	// Submodules
	// ----------------------------------------
	fpm_ip_sel u_ip (
		.clk(hclk),
		.rst_n(hresetn),
		.ce(ce),
		.dip_sw(dip_sw),
		.dhcp_en(ctrl_r[`FPM_CTRL_DHCP]),
		.fixed_valid(ctrl_r[`FPM_CTRL_FIXV]),
		.fixed_octet(ctrl_r[15:8]),
		.dhcp_grant(dhcp_grant),
		.dhcp_octet(dhcp_octet),
		.octet_r(ip_octet),
		.use_dhcp_r(use_dhcp),
		.addr_ok_r(addr_ok)
	);

	fpm_tbl_mem #(.AW(MAW), .DW(8)) u_mem (
		.clk(hclk),
		.ce(ce),
		.we(wr_pend_r && wr_ofs_r == `FPM_OFS_TDATA),
		.wa(taddr_r),
		.wd(hwdata[7:0]),
		.ra(mem_ra),
		.rd_r(mem_rd)
	);

	// ----------------------------------------
	// Register read mux
	// ----------------------------------------
	always @* begin
		rd_mux = 32'h0000_0000;
		case (haddr[7:0])
			`FPM_OFS_CTRL: rd_mux = ctrl_r;
			`FPM_OFS_STAT: rd_mux = {{(32-`FPM_EV_W){1'b0}}, stat_r};
			`FPM_OFS_MASK: rd_mux = {{(32-`FPM_EV_W){1'b0}}, mask_r};
			`FPM_OFS_IPADDR: rd_mux = {`FPM_IP_PREFIX, ip_octet};
			`FPM_OFS_NETMASK: rd_mux = `FPM_NETMASK;
			`FPM_OFS_INFO: rd_mux = {`FPM_INST_CFG,
				short_asm ? `FPM_INST_OUT_SHORT : `FPM_INST_OUT_LONG,
				short_asm ? `FPM_INST_IN_SHORT : `FPM_INST_IN_LONG,
				6'h00, use_dhcp, addr_ok};
			`FPM_OFS_TADDR: rd_mux = {{(32-MAW){1'b0}}, taddr_r};
			default: begin
				if (haddr[7:4] == `FPM_OFS_INSEL >> 4) begin
					rd_mux = in_sel_r[sel_word(haddr[7:0])*32 +: 32];
				end else if (haddr[7:4] == `FPM_OFS_OUTSEL >> 4) begin
					rd_mux = out_sel_r[sel_word(haddr[7:0])*32 +: 32];
				end
			end
		endcase
	end

	// ----------------------------------------
	// AHB-Lite slave
	// ----------------------------------------
	// Zero wait states: read data registered in the address phase
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			wr_pend_r <= 1'b0;
			wr_ofs_r <= 8'h00;
			ctrl_r <= `FPM_CTRL_RST;
			mask_r <= {`FPM_EV_W{1'b0}};
			taddr_r <= {MAW{1'b0}};
			in_sel_r <= {4{`FPM_SEL_RST}};
			out_sel_r <= {4{`FPM_SEL_RST}};
		end else if (ce) begin
			wr_pend_r <= acc & hwrite;
			if (acc) begin
				wr_ofs_r <= haddr[7:0];
			end
			if (acc & ~hwrite) begin
				hrdata <= rd_mux;
			end
			if (wr_pend_r) begin
				case (wr_ofs_r)
					`FPM_OFS_CTRL: ctrl_r <= {16'h0000, hwdata[15:8], 5'h00, hwdata[2:0]};
					`FPM_OFS_MASK: mask_r <= hwdata[`FPM_EV_W-1:0];
					`FPM_OFS_TADDR: taddr_r <= hwdata[MAW-1:0];
					`FPM_OFS_TDATA: taddr_r <= taddr_r + 1'b1;
					default: begin
						if (wr_ofs_r[7:4] == `FPM_OFS_INSEL >> 4) begin
							in_sel_r[sel_word(wr_ofs_r)*32 +: 32] <= hwdata;
						end else if (wr_ofs_r[7:4] == `FPM_OFS_OUTSEL >> 4) begin
							out_sel_r[sel_word(wr_ofs_r)*32 +: 32] <= hwdata;
						end
					end
				endcase
			end
		end
	end

	// ----------------------------------------
	// Status, mask and interrupt
	// ----------------------------------------
	// Set wins over the read clear
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stat_r <= {`FPM_EV_W{1'b0}};
			irq <= 1'b0;
			prev_ok_r <= 1'b0;
		end else if (ce) begin
			prev_ok_r <= addr_ok;
			if (acc & ~hwrite & (haddr[7:0] == `FPM_OFS_STAT)) begin
				stat_r <= ev;
			end else begin
				stat_r <= stat_r | ev;
			end
			irq <= |((stat_r | ev) & mask_r);
		end
	end

	// ----------------------------------------
	// Receive path
	// ----------------------------------------
	always @* begin
		ev = {`FPM_EV_W{1'b0}};
		ev[`FPM_EV_ADDR] = addr_ok & ~prev_ok_r;
		if (rx_valid & rx_last & link_up) begin
			if (rx_cnt_r + 1'b1 != asm_len) begin
				ev[`FPM_EV_LENERR] = 1'b1;
			end else if (state_r != S_IDLE) begin
				ev[`FPM_EV_OVR] = 1'b1;
			end else begin
				ev[`FPM_EV_DONE] = 1'b1;
			end
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_cnt_r <= 6'd0;
			in_shadow_r <= 128'h0;
			ctl_inputs <= 128'h0;
			tbl_r <= 8'h00;
			seg_r <= 8'h00;
			link_up <= 1'b0;
			dhcp_req <= 1'b0;
		end else if (ce) begin
			// Self start once an address is held
			link_up <= addr_ok & ~ctl_reset;
			dhcp_req <= use_dhcp & ~addr_ok;
			if (ctl_reset) begin
				rx_cnt_r <= 6'd0;
				ctl_inputs <= 128'h0;
				tbl_r <= 8'h00;
				seg_r <= 8'h00;
			end else if (rx_valid & link_up) begin
				rx_cnt_r <= rx_last ? 6'd0 : rx_cnt_r + 1'b1;
				if (rx_cnt_r < `FPM_IO_BYTES) begin
					// Byte n div 8, bit n mod 8
					in_shadow_r[rx_cnt_r[3:0]*8 +: 8] <= rx_data;
				end
				if (ev[`FPM_EV_DONE]) begin
					ctl_inputs <= in_shadow_r & in_sel_r;
				end
				if (rx_cnt_r == `FPM_TBL_BYTE) begin
					tbl_r <= short_asm ? 8'h00 : rx_data;
				end
				if (rx_cnt_r == `FPM_SEG_BYTE) begin
					seg_r <= short_asm ? 8'h00 : rx_data;
				end
			end
		end
	end

	// ----------------------------------------
	// Transmit path
	// ----------------------------------------
	always @* begin
		byte_mux = 8'h00;
		if (idx_r < `FPM_IO_BYTES) begin
			byte_mux = out_img[idx_r[3:0]*8 +: 8];
		end else if (idx_r == `FPM_STAT_BYTE) begin
			byte_mux = status_byte;
		end else if (seg_hit & ~short_asm) begin
			byte_mux = mem_rd;
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_r <= S_IDLE;
			idx_r <= 6'd0;
			tx_valid <= 1'b0;
			tx_data <= 8'h00;
			tx_last <= 1'b0;
		end else if (ce) begin
			if (ctl_reset) begin
				state_r <= S_IDLE;
				tx_valid <= 1'b0;
				tx_last <= 1'b0;
			end else begin
				case (state_r)
					S_IDLE: begin
						if (ev[`FPM_EV_DONE]) begin
							idx_r <= 6'd0;
							state_r <= S_FETCH;
						end
					end
					// Memory read latency costs one cycle per byte
					S_FETCH: state_r <= S_LOAD;
					S_LOAD: begin
						tx_data <= byte_mux;
						tx_valid <= 1'b1;
						tx_last <= (idx_r + 1'b1 == asm_len);
						state_r <= S_SEND;
					end
					S_SEND: begin
						if (tx_ready) begin
							tx_valid <= 1'b0;
							tx_last <= 1'b0;
							idx_r <= idx_r + 1'b1;
							state_r <= tx_last ? S_IDLE : S_FETCH;
						end
					end
					default: state_r <= S_IDLE;
				endcase
			end
		end
	end
endmodule // fpm_top

// *** shared/fpm_regs.vh ***
// Constants of the fieldbus process image mapper: register map, fields,
// reset values, assembly lengths and network address constants.
// Assumes inclusion by bare name from the design files.
`ifndef FPM_REGS_VH
`define FPM_REGS_VH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define FPM_OFS_CTRL 8'h00
`define FPM_OFS_STAT 8'h04
`define FPM_OFS_MASK 8'h08
`define FPM_OFS_IPADDR 8'h0c
`define FPM_OFS_NETMASK 8'h10
`define FPM_OFS_INFO 8'h14
`define FPM_OFS_TADDR 8'h18
`define FPM_OFS_TDATA 8'h1c
`define FPM_OFS_INSEL 8'h20
`define FPM_OFS_OUTSEL 8'h30

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define FPM_CTRL_SHORT 0
`define FPM_CTRL_DHCP 1
`define FPM_CTRL_FIXV 2
`define FPM_CTRL_RST 32'h0000_0002
`define FPM_SEL_RST 32'hffff_ffff
`define FPM_EV_DONE 0
`define FPM_EV_LENERR 1
`define FPM_EV_OVR 2
`define FPM_EV_ADDR 3
`define FPM_EV_W 4
`define FPM_ST_XCHG 5

// ----------------------------------------
// Assemblies and network address
// ----------------------------------------
`define FPM_LEN_LONG 6'd32
`define FPM_LEN_SHORT 6'd17
`define FPM_IO_BYTES 6'd16
`define FPM_STAT_BYTE 6'd16
`define FPM_TBL_BYTE 6'd16
`define FPM_SEG_BYTE 6'd17
`define FPM_SEG_LEN 4'd15
`define FPM_INST_IN_LONG 8'd100
`define FPM_INST_IN_SHORT 8'd101
`define FPM_INST_OUT_LONG 8'd150
`define FPM_INST_OUT_SHORT 8'd151
`define FPM_INST_CFG 8'd4
`define FPM_IP_PREFIX 24'hc0_a8_01
`define FPM_NETMASK 32'hffff_ff00
`define FPM_DIP_DHCP 8'hff

`endif

// *** verilog/fpm_tbl_mem.v ***
// Payload table store: one write port from software, one read port for
// the transmitter. Assumes a single clock; read data come from a register.
`timescale 1ns/1ps

module fpm_tbl_mem #(
	parameter AW = 9,
	parameter DW = 8
) (
	input wire clk,
	input wire ce,
	input wire we,
	input wire [AW-1:0] wa,
	input wire [DW-1:0] wd,
	input wire [AW-1:0] ra,
	output reg [DW-1:0] rd_r
);
	reg [DW-1:0] mem [0:(1<<AW)-1];

	// No reset: contents are software's to load
	always @(posedge clk) begin
		if (ce) begin
			if (we) begin
				mem[wa] <= wd;
			end
			rd_r <= mem[ra];
		end
	end
endmodule // fpm_tbl_mem

// *** verilog/fpm_ip_sel.v ***
// Chooses the node address: front switch, stored fixed octet or DHCP.
// Assumes all inputs synchronous to clk.
`timescale 1ns/1ps
`include "fpm_regs.vh"

module fpm_ip_sel (
	input wire clk,
	input wire rst_n,
	input wire ce,
	input wire [7:0] dip_sw,
	input wire dhcp_en,
	input wire fixed_valid,
	input wire [7:0] fixed_octet,
	input wire dhcp_grant,
	input wire [7:0] dhcp_octet,
	output reg [7:0] octet_r,
	output reg use_dhcp_r,
	output reg addr_ok_r
);
	reg [7:0] octet_nxt;
	reg use_dhcp_nxt;
	reg addr_ok_nxt;

	always @* begin
		octet_nxt = 8'h00;
		use_dhcp_nxt = 1'b0;
		addr_ok_nxt = 1'b0;
		if (dip_sw == `FPM_DIP_DHCP) begin
			use_dhcp_nxt = 1'b1;
		end else if (dip_sw != 8'h00) begin
			octet_nxt = dip_sw;
			addr_ok_nxt = 1'b1;
		end else if (fixed_valid) begin
			octet_nxt = fixed_octet;
			addr_ok_nxt = 1'b1;
		end else if (dhcp_en) begin
			use_dhcp_nxt = 1'b1;
		end
		if (use_dhcp_nxt) begin
			octet_nxt = dhcp_octet;
			addr_ok_nxt = dhcp_grant;
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			octet_r <= 8'h00;
			use_dhcp_r <= 1'b0;
			addr_ok_r <= 1'b0;
		end else if (ce) begin
			octet_r <= octet_nxt;
			use_dhcp_r <= use_dhcp_nxt;
			addr_ok_r <= addr_ok_nxt;
		end
	end
endmodule // fpm_ip_sel

// *** verification/fpm_scn.sv ***
// Scanner model: sends input assemblies, collects output assemblies.
// Assumes the bench calls send just after a rising edge of hclk.
`timescale 1ns/1ps

module fpm_scn (
	input wire hclk,
	output reg rx_valid = 1'b0,
	output reg [7:0] rx_data = 8'h0,
	output reg rx_last = 1'b0,
	input wire tx_valid,
	input wire [7:0] tx_data,
	input wire tx_last,
	output reg tx_ready = 1'b0
);
	reg [7:0] rxb [0:31];
	reg [7:0] txq [$];
	integer n_last = 0;
	reg stall = 1'b0;

	task send(input integer n);
		integer i;
		for (i = 0; i < n; i = i + 1) begin
			@(posedge hclk);
			rx_valid <= 1'b1;
			rx_data <= rxb[i];
			rx_last <= (i == n - 1);
		end
		@(posedge hclk);
		rx_valid <= 1'b0;
		rx_last <= 1'b0;
		// Idle data inverted so a stale byte never looks valid
		rx_data <= ~rx_data;
	endtask

	// Whole output assembly; stall halves rate
	always @(posedge hclk) begin
		tx_ready <= stall ? ~tx_ready : 1'b1;
		if (tx_valid && tx_ready) begin
			txq.push_back(tx_data);
			n_last <= n_last + tx_last;
		end
	end
endmodule // fpm_scn

// *** verification/fpm_top_assertions.sv ***
// Checker on the mapper's top ports.
// Assumes ce held high throughout.
`timescale 1ns/1ps

module fpm_chk (
	input wire hclk,
	input wire hresetn,
	input wire rx_valid,
	input wire rx_last,
	input wire tx_valid,
	input wire [7:0] tx_data,
	input wire tx_last,
	input wire tx_ready,
	input wire [127:0] ctl_outputs,
	input wire output_fault_indicator,
	input wire input_fault_indicator,
	input wire fault_indicator,
	input wire diagnostic_indicator,
	input wire run_indicator,
	input wire ctl_xchg_active,
	input wire ctl_reset,
	input wire [127:0] ctl_inputs,
	input wire [7:0] dip_sw,
	input wire dhcp_grant,
	input wire dhcp_req,
	input wire link_up
);
	// ----
	// Byte counter of the output assembly
	// ----
	reg [5:0] txc_r;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			txc_r <= 6'h0;
		else if (ctl_reset)
			txc_r <= 6'h0;
		else if (tx_valid && tx_ready)
			txc_r <= tx_last ? 6'h0 : txc_r + 6'h1;
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	property p_len;
		tx_valid && tx_ready && tx_last |-> txc_r == 6'd16 || txc_r == 6'd31;
	endproperty
	a_len: assert property (p_len) else $error("tx length wrong");
	property p_hold;
		tx_valid && !tx_ready && !ctl_reset |=> tx_valid && $stable(tx_data) && $stable(tx_last);
	endproperty
	a_hold: assert property (p_hold) else $error("tx byte dropped");
	property p_start;
		$rose(tx_valid) && txc_r == 6'h0 |-> $past(rx_valid && rx_last, 3);
	endproperty
	a_start: assert property (p_start) else $error("tx start late");
	property p_obyte;
		tx_valid && txc_r < 6'd16 |-> (tx_data & ~ctl_outputs[{txc_r[3:0], 3'b0} +: 8]) == 8'h0;
	endproperty
	a_obyte: assert property (p_obyte) else $error("output bit wrong");
	property p_stat;
		tx_valid && txc_r == 6'd16 |-> tx_data == {2'b00, ctl_xchg_active, run_indicator,
			diagnostic_indicator, fault_indicator, input_fault_indicator, output_fault_indicator};
	endproperty
	a_stat: assert property (p_stat) else $error("status byte wrong");
	property p_dhcp;
		dhcp_req |-> !link_up;
	endproperty
	a_dhcp: assert property (p_dhcp) else $error("link without address");
	property p_force;
		(dip_sw == 8'hff && !dhcp_grant)[*4] |-> dhcp_req && !link_up;
	endproperty
	a_force: assert property (p_force) else $error("switch 255 not dhcp");
	property p_dip;
		(dip_sw != 8'h0 && dip_sw != 8'hff && !ctl_reset)[*4] |-> link_up && !dhcp_req;
	endproperty
	a_dip: assert property (p_dip) else $error("switch address unused");
	property p_rst;
		ctl_reset |=> !link_up && !tx_valid && ctl_inputs == 128'h0;
	endproperty
	a_rst: assert property (p_rst) else $error("controller reset ignored");

	c_long: cover property (tx_valid && tx_ready && tx_last && txc_r == 6'd31);
	c_stall: cover property (tx_valid && !tx_ready);
	c_force: cover property (dip_sw == 8'hff && dhcp_req);
endmodule // fpm_chk

bind fpm_top fpm_chk u_chk (.hclk, .hresetn, .rx_valid, .rx_last, .tx_valid, .tx_data,
	.tx_last, .tx_ready, .ctl_outputs, .output_fault_indicator, .input_fault_indicator,
	.fault_indicator, .diagnostic_indicator, .run_indicator, .ctl_xchg_active, .ctl_reset,
	.ctl_inputs, .dip_sw, .dhcp_grant, .dhcp_req, .link_up);

// *** verification/fpm_tb_top.sv ***
// Bench for the mapper: registers, address choice, frames, errors.
// Assumes the scanner model and checker are compiled first.
`timescale 1ns/1ps
`include "fpm_regs.vh"

module fieldbus_process_image_mapper_tb_top;
	reg hclk = 1'b0;
	reg hresetn = 1'b0;
	reg hsel = 1'b0;
	reg [31:0] haddr = 32'h0;
	reg [1:0] htrans = 2'h0;
	reg hwrite = 1'b0;
	reg [31:0] hwdata = 32'h0;
	reg [127:0] outs = 128'h0123456789abcdef_fedcba9876543210;
	reg [5:0] led = 6'h35;
	reg ctl_reset = 1'b0;
	reg [7:0] dip = 8'h0;
	reg grant = 1'b0;
	wire [31:0] hrdata;
	wire hresp;
	wire hreadyout, irq, rx_valid, rx_last, tx_valid, tx_last, tx_ready, dhcp_req, link_up;
	wire [7:0] rx_data, tx_data;
	wire [127:0] ctl_inputs;
	reg [31:0] rd;
	integer num_errors = 0;
	integer n_compared = 0;

	fpm_top u_dut (.hclk, .hresetn, .ce(1'b1), .hsel, .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .irq,
		.rx_valid, .rx_data, .rx_last, .tx_valid, .tx_data, .tx_last, .tx_ready,
		.ctl_outputs(outs), .output_fault_indicator(led[0]), .input_fault_indicator(led[1]),
		.fault_indicator(led[2]), .diagnostic_indicator(led[3]), .run_indicator(led[4]),
		.ctl_xchg_active(led[5]), .ctl_reset, .ctl_inputs, .dip_sw(dip), .dhcp_grant(grant),
		.dhcp_octet(8'h37), .dhcp_req, .link_up);
	fpm_scn u_scn (.hclk, .rx_valid, .rx_data, .rx_last, .tx_valid, .tx_data, .tx_last,
		.tx_ready);

	initial forever #50 hclk = ~hclk;

	// ----
	// Tasks
	// ----
	task ck(input string nm, input [31:0] e, input [31:0] g);
		n_compared = n_compared + 1;
		if (g !== e) begin
			num_errors = num_errors + 1;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask
	task bus(input w, input [7:0] a, input [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask
	task rdck(input string nm, input [7:0] a, input [31:0] e);
		bus(1'b0, a, 32'h0);
		ck(nm, e, rd);
		ck("hresp", 0, hresp);
	endtask
	task cyc(input integer n);
		repeat (n) @(posedge hclk);
		@(negedge hclk);
	endtask
	task frm(input integer n, input [31:0] sel);
		integer k;
		reg [127:0] ei;
		reg [127:0] eo;
		reg [31:0] eb;
		u_scn.txq.delete();
		u_scn.n_last = 0;
		for (k = 0; k < 32; k = k + 1) u_scn.rxb[k] = (k < 16) ? 8'(k * 29) : 8'h0;
		u_scn.rxb[16] = 8'h1;
		u_scn.rxb[17] = 8'h2;
		u_scn.send(n);
		for (k = 0; k < 400 && u_scn.txq.size() < n; k = k + 1) @(posedge hclk);
		cyc(8);
		for (k = 0; k < 16; k = k + 1) ei[8*k +: 8] = u_scn.rxb[k];
		ei[31:0] = ei[31:0] & sel;
		eo = outs;
		eo[31:0] = eo[31:0] & sel;
		for (k = 0; k < 4; k = k + 1) begin
			ck("inputs", ei[32*k +: 32], ctl_inputs[32*k +: 32]);
		end
		ck("tx count", n, u_scn.txq.size());
		ck("tx last", 1, u_scn.n_last);
		for (k = 0; k < n && k < u_scn.txq.size(); k = k + 1) begin
			eb = (k < 16) ? eo[8*k +: 8] : ((k == 16) ? {2'b00, led} : k + 8'h2f);
			ck("tx byte", eb, u_scn.txq[k]);
		end
	endtask

	task t_addr;
		rdck("ctrl", `FPM_OFS_CTRL, 32'h2);
		rdck("netmask", `FPM_OFS_NETMASK, 32'hffffff00);
		rdck("unmapped", 8'h40, 32'h0);
		cyc(2);
		ck("dhcp_req", 1, dhcp_req);
		ck("link_up", 0, link_up);
		@(posedge hclk);
		grant <= 1'b1;
		cyc(3);
		ck("link_up", 1, link_up);
		rdck("ip dhcp", `FPM_OFS_IPADDR, 32'hc0a80137);
		@(posedge hclk);
		dip <= 8'h14;
		cyc(3);
		ck("dhcp_req", 0, dhcp_req);
		rdck("ip switch", `FPM_OFS_IPADDR, 32'hc0a80114);
		bus(1'b1, `FPM_OFS_CTRL, 32'h2a06);
		dip <= 8'hff;
		grant <= 1'b0;
		cyc(4);
		ck("forced", 0, link_up);
		ck("forced dhcp", 1, dhcp_req);
		@(posedge hclk);
		dip <= 8'h0;
		cyc(3);
		rdck("ip fixed", `FPM_OFS_IPADDR, 32'hc0a8012a);
		$display("test address done");
	endtask
	task t_frames;
		integer i;
		bus(1'b1, `FPM_OFS_CTRL, 32'h2);
		bus(1'b1, `FPM_OFS_TADDR, 32'ha0);
		for (i = 0; i < 15; i = i + 1) bus(1'b1, `FPM_OFS_TDATA, i + 32'h40);
		dip <= 8'h05;
		u_scn.stall = 1'b1;
		cyc(3);
		rdck("info long", `FPM_OFS_INFO, 32'h04966401);
		frm(32, 32'hffffffff);
		u_scn.stall = 1'b0;
		bus(1'b1, `FPM_OFS_CTRL, 32'h3);
		bus(1'b1, `FPM_OFS_INSEL, 32'h0);
		bus(1'b1, `FPM_OFS_OUTSEL, 32'h0);
		led <= 6'h0a;
		rdck("info short", `FPM_OFS_INFO, 32'h04976501);
		frm(17, 32'h0);
		$display("test frames done");
	endtask
	task t_err;
		bus(1'b1, `FPM_OFS_CTRL, 32'h2);
		bus(1'b1, `FPM_OFS_MASK, 32'h2);
		bus(1'b0, `FPM_OFS_STAT, 32'h0);
		u_scn.txq.delete();
		u_scn.send(17);
		cyc(3);
		ck("irq", 1, irq);
		rdck("stat", `FPM_OFS_STAT, 32'h2);
		cyc(2);
		ck("irq clear", 0, irq);
		ck("no tx", 0, u_scn.txq.size());
		// Second frame ends while the first is still going out
		u_scn.send(32);
		u_scn.send(32);
		cyc(1);
		ck("irq masked", 0, irq);
		rdck("stat overrun", `FPM_OFS_STAT, 32'h5);
		$display("test length error done");
	endtask
	task t_rst;
		@(posedge hclk);
		ctl_reset <= 1'b1;
		cyc(1);
		ck("link down", 0, link_up);
		ck("inputs clear", 0, ctl_inputs[63:32]);
		@(posedge hclk);
		ctl_reset <= 1'b0;
		cyc(4);
		ck("restart", 1, link_up);
		$display("test controller reset done");
	endtask
	task end_sim;
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		t_addr;
		t_frames;
		t_err;
		t_rst;
		end_sim;
	end
	// Far beyond the few hundred cycles the tests need
	initial begin
		#2000000;
		num_errors = num_errors + 1;
		end_sim;
	end
endmodule // fieldbus_process_image_mapper_tb_top
